// [pkg/itt_pkg.sv]
// Constants, register map and carrier types of the inactivity timeout timer.
package itt_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam longint unsigned ITT_CLK_HZ = 64'h0000_0000_0773_5940;
   localparam longint unsigned ITT_MINUTE_S = 64'h0000_0000_0000_003C;
   localparam longint unsigned ITT_TICK_CYCLES = ITT_MINUTE_S * ITT_CLK_HZ;
   localparam int ITT_PRESC_W = 33;
   localparam logic [ITT_PRESC_W-1:0] ITT_PRESC_ZERO = 33'h0_0000_0000;
   localparam logic [ITT_PRESC_W-1:0] ITT_PRESC_ONE = 33'h0_0000_0001;

   // ---------------------------------------------------------------
   // Register map (word indices; byte address is four times the index)
   // ---------------------------------------------------------------
   localparam int ITT_ADR_W = 8;
   localparam logic [5:0] ITT_IDX_TIMEOUT = 6'h00;
   localparam logic [5:0] ITT_IDX_MASK = 6'h01;
   localparam logic [5:0] ITT_IDX_STATUS = 6'h02;
   localparam logic [5:0] ITT_IDX_ROUTE = 6'h04;
   localparam logic [5:0] ITT_IDX_INT_STAT = 6'h05;
   localparam logic [5:0] ITT_IDX_INT_MASK = 6'h06;
   localparam logic [1:0] ITT_ADR_ALIGN = 2'h0;

   // ---------------------------------------------------------------
   // Fields and reset values
   // ---------------------------------------------------------------
   localparam int ITT_SRC_N = 4;
   localparam int ITT_ROUTE_EN_BIT = 7;
   localparam int ITT_ROUTE_SEL_W = 4;
   localparam int ITT_IRQ_LINES = 16;
   localparam int ITT_EV_N = 2;
   localparam int ITT_EV_EXPIRE = 0;
   localparam int ITT_EV_RELOAD = 1;
   localparam logic [7:0] ITT_PERIOD_RST = 8'h00;
   localparam logic [7:0] ITT_COUNT_ZERO = 8'h00;
   localparam logic [7:0] ITT_COUNT_ONE = 8'h01;
   localparam logic [ITT_SRC_N-1:0] ITT_MASK_RST = 4'h0;
   localparam logic [7:0] ITT_ROUTE_RST = 8'h00;
   localparam logic [ITT_EV_N-1:0] ITT_EV_RST = 2'h0;
   localparam logic [31:0] ITT_DAT_ZERO = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ITT_ADR_W-1:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } itt_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } itt_wb_rsp_t;

   typedef struct packed {
      logic [7:0] period;
      logic [ITT_SRC_N-1:0] mask;
      logic [7:0] count;
      logic running;
      logic alert_n;
      logic [ITT_SRC_N-1:0] act_prev;
      logic [ITT_PRESC_W-1:0] presc;
      logic [7:0] route;
      logic [ITT_EV_N-1:0] int_stat;
      logic [ITT_EV_N-1:0] int_mask;
      logic ack;
      logic [31:0] rdata;
   } itt_state_t;

endpackage

// [core/itt_timer.sv]
// Inactivity timeout timer with classic Wishbone register slave.
//
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
// Notes on behaviour
// - Eight-bit counter, one decrement per minute.
// - Four maskable activity sources watched.
// - Expiry drives active-low alert pin.
// - Expiry readable as status, routable IRQ.
// - Reset: period zero, idle, alert high, masked.
// - Nonzero timeout write starts and loads counter.
// - Unmasked activity reloads counter from period.
// - Reaching zero stops, alert low, status zero.
// - Any timeout write releases alert, status one.
// - Zero write stops timer; nonzero restarts.
// - Status bit mirrors alert output level.
// - Routed IRQ active while status zero.
// - Nonzero write while running reloads immediately.
// - Mask bits 3..0 enable sources; rest zero.
module itt_timer
   import itt_pkg::*;
#(
   parameter logic [ITT_PRESC_W-1:0] TICK_CYCLES = ITT_PRESC_W'(ITT_TICK_CYCLES)
) (
   input wire logic clk,
   input wire logic srst,
   input wire itt_wb_req_t wb_req,
   output itt_wb_rsp_t wb_rsp,
   input wire logic [ITT_SRC_N-1:0] activity_irq,
   output logic alert_out_n,
   output logic [ITT_IRQ_LINES-1:0] alert_irq,
   output logic irq
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   itt_state_t state_ff;
   itt_state_t nxt_state;

   localparam logic [ITT_PRESC_W-1:0] TICK_LAST = TICK_CYCLES - ITT_PRESC_ONE;

   logic bus_req;
   logic bus_wr;
   logic bus_rd;
   logic [5:0] bus_idx;
   logic idx_ok;
   logic wr_timeout;
   logic act_hit;
   logic tick;
   logic [ITT_EV_N-1:0] events;
   logic [31:0] rd_mux;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   // A request is taken once; state_ff.ack blocks the second cycle of the same request.
   assign bus_req = wb_req.cyc & wb_req.stb & ~state_ff.ack;
   assign bus_wr = bus_req & wb_req.we & wb_req.sel[0];
   assign bus_rd = bus_req & ~wb_req.we;
   assign bus_idx = wb_req.adr[ITT_ADR_W-1:2];
   assign idx_ok = (wb_req.adr[1:0] == ITT_ADR_ALIGN);
   assign wr_timeout = bus_wr & idx_ok & (bus_idx == ITT_IDX_TIMEOUT);

   // Activity is the rising edge of an enabled source.
   assign act_hit = |(activity_irq & ~state_ff.act_prev & state_ff.mask);
   assign tick = state_ff.running & (state_ff.presc == TICK_LAST);

   always_comb begin
      rd_mux = ITT_DAT_ZERO;
      if (idx_ok) begin
         unique case (bus_idx)
            ITT_IDX_TIMEOUT: begin
               rd_mux[7:0] = state_ff.period;
            end
            ITT_IDX_MASK: begin
               rd_mux[ITT_SRC_N-1:0] = state_ff.mask;
            end
            ITT_IDX_STATUS: begin
               rd_mux[0] = state_ff.alert_n;
            end
            ITT_IDX_ROUTE: begin
               rd_mux[7:0] = state_ff.route;
            end
            ITT_IDX_INT_STAT: begin
               rd_mux[ITT_EV_N-1:0] = state_ff.int_stat;
            end
            ITT_IDX_INT_MASK: begin
               rd_mux[ITT_EV_N-1:0] = state_ff.int_mask;
            end
            default: begin
               rd_mux = ITT_DAT_ZERO;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      events = ITT_EV_RST;
      nxt_state.act_prev = activity_irq;
      nxt_state.ack = bus_req;
      if (bus_req) begin
         nxt_state.rdata = bus_rd ? rd_mux : ITT_DAT_ZERO;
      end

      // Countdown runs only while active; activity while idle is ignored.
      if (state_ff.running) begin
         if (act_hit) begin
            nxt_state.count = state_ff.period;
            nxt_state.presc = ITT_PRESC_ZERO;
            events[ITT_EV_RELOAD] = 1'b1;
         end else if (tick) begin
            nxt_state.presc = ITT_PRESC_ZERO;
            if (state_ff.count == ITT_COUNT_ONE) begin
               nxt_state.count = ITT_COUNT_ZERO;
               nxt_state.running = 1'b0;
               nxt_state.alert_n = 1'b0;
               events[ITT_EV_EXPIRE] = 1'b1;
            end else begin
               nxt_state.count = state_ff.count - ITT_COUNT_ONE;
            end
         end else begin
            nxt_state.presc = state_ff.presc + ITT_PRESC_ONE;
         end
      end

      // A timeout write overrides the counter and alert effects of any activity or tick in the same cycle; their events still set int_stat.
      if (wr_timeout) begin
         nxt_state.period = wb_req.dat[7:0];
         nxt_state.alert_n = 1'b1;
         nxt_state.presc = ITT_PRESC_ZERO;
         nxt_state.count = wb_req.dat[7:0];
         nxt_state.running = (wb_req.dat[7:0] != ITT_COUNT_ZERO);
      end

      if (bus_wr && idx_ok) begin
         unique case (bus_idx)
            ITT_IDX_MASK: begin
               nxt_state.mask = wb_req.dat[ITT_SRC_N-1:0];
            end
            ITT_IDX_ROUTE: begin
               nxt_state.route = wb_req.dat[7:0];
            end
            ITT_IDX_INT_MASK: begin
               nxt_state.int_mask = wb_req.dat[ITT_EV_N-1:0];
            end
            default: begin
            end
         endcase
      end

      // Reading the event status clears it, but a new event in that cycle survives.
      if (bus_rd && idx_ok && (bus_idx == ITT_IDX_INT_STAT)) begin
         nxt_state.int_stat = events;
      end else begin
         nxt_state.int_stat = state_ff.int_stat | events;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff.period <= ITT_PERIOD_RST;
         state_ff.mask <= ITT_MASK_RST;
         state_ff.count <= ITT_COUNT_ZERO;
         state_ff.running <= 1'b0;
         state_ff.alert_n <= 1'b1;
         state_ff.act_prev <= ITT_MASK_RST;
         state_ff.presc <= ITT_PRESC_ZERO;
         state_ff.route <= ITT_ROUTE_RST;
         state_ff.int_stat <= ITT_EV_RST;
         state_ff.int_mask <= ITT_EV_RST;
         state_ff.ack <= 1'b0;
         state_ff.rdata <= ITT_DAT_ZERO;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign wb_rsp.ack = state_ff.ack;
   assign wb_rsp.dat = state_ff.rdata;
   assign alert_out_n = state_ff.alert_n;

   // Only the selected line can go high; every other line is driven low rather than floating.
   for (genvar g = 0; g < ITT_IRQ_LINES; g++) begin : g_route
      assign alert_irq[g] = state_ff.route[ITT_ROUTE_EN_BIT] & ~state_ff.alert_n &
         (state_ff.route[ITT_ROUTE_SEL_W-1:0] == ITT_ROUTE_SEL_W'(g));
   end

   assign irq = |(state_ff.int_stat & state_ff.int_mask);

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_reset_values: assert property (@(posedge clk) disable iff (1'b0) srst |=>
      (state_ff.period == ITT_PERIOD_RST) && !state_ff.running && state_ff.alert_n &&
      (state_ff.mask == ITT_MASK_RST))
      else $error("reset state wrong");

   a_write_loads: assert property (wr_timeout && (wb_req.dat[7:0] != ITT_COUNT_ZERO) |=>
      state_ff.running && (state_ff.count == $past(wb_req.dat[7:0])) && (state_ff.presc == ITT_PRESC_ZERO))
      else $error("timeout write did not load counter");

   a_zero_stops: assert property (wr_timeout && (wb_req.dat[7:0] == ITT_COUNT_ZERO) |=>
      !state_ff.running ##1 !state_ff.running && state_ff.alert_n)
      else $error("zero write did not stop timer");

   a_write_release: assert property (wr_timeout |=> state_ff.alert_n && alert_out_n)
      else $error("timeout write did not release alert");

   a_activity_reload: assert property (state_ff.running && act_hit && !wr_timeout |=>
      (state_ff.count == $past(state_ff.period)) && state_ff.running)
      else $error("activity did not reload counter");

   a_expiry_alert: assert property (tick && (state_ff.count == ITT_COUNT_ONE) && !act_hit && !wr_timeout |=>
      !alert_out_n && !state_ff.running && (state_ff.count == ITT_COUNT_ZERO) ##1
      (!alert_out_n || $past(wr_timeout)))
      else $error("expiry did not assert alert");

   a_count_steady: assert property (state_ff.running && !tick && !act_hit && !wr_timeout |=>
      $stable(state_ff.count))
      else $error("counter moved without minute tick");

   a_status_mirror: assert property (bus_rd && idx_ok && (bus_idx == ITT_IDX_STATUS) |=>
      wb_rsp.ack && (wb_rsp.dat == {31'h0000_0000, $past(alert_out_n)}))
      else $error("status read does not mirror alert");

   a_route_level: assert property ($fell(alert_out_n) && state_ff.route[ITT_ROUTE_EN_BIT] |->
      (alert_irq == (16'h0001 << state_ff.route[ITT_ROUTE_SEL_W-1:0])))
      else $error("routed interrupt line not active");

   a_mask_reserved: assert property (bus_rd && idx_ok && (bus_idx == ITT_IDX_MASK) |=>
      (wb_rsp.dat[31:ITT_SRC_N] == 28'h000_0000))
      else $error("mask reserved bits read nonzero");

   a_tick_single: assert property (tick |=> !tick [*3])
      else $error("minute tick longer than one cycle");

   a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
      else $error("ack held for more than one cycle");

   // ---------------------------------------------------------------
   // Invariant and register assertions
   // ---------------------------------------------------------------

   a_reset_outputs: assert property (@(posedge clk) disable iff (1'b0) srst |=>
      alert_out_n && !wb_rsp.ack && !irq && (alert_irq == 16'h0000))
      else $error("outputs not idle after reset");

   a_alert_stays: assert property (!alert_out_n && !wr_timeout |=>
      !alert_out_n)
      else $error("alert released without timeout write");

   a_alert_cause: assert property ($fell(alert_out_n) |->
      $past(tick) && ($past(state_ff.count) == ITT_COUNT_ONE))
      else $error("alert fell without final tick");

   a_expiry_event: assert property ($fell(alert_out_n) |->
      state_ff.int_stat[ITT_EV_EXPIRE])
      else $error("expiry event not recorded");

   a_irq_expiry: assert property ($rose(state_ff.int_stat[ITT_EV_EXPIRE]) && state_ff.int_mask[ITT_EV_EXPIRE] |->
      irq)
      else $error("enabled expiry event did not raise irq");

   a_idle_frozen: assert property (!state_ff.running && !wr_timeout |=>
      !state_ff.running && $stable(state_ff.count) && $stable(state_ff.presc))
      else $error("stopped timer moved");

   a_idle_ignores: assert property (!state_ff.running && !wr_timeout |=>
      !$rose(state_ff.int_stat[ITT_EV_RELOAD]))
      else $error("activity acted on a stopped timer");

   a_running_valid: assert property (state_ff.running |->
      (state_ff.period != ITT_PERIOD_RST) && (state_ff.count != ITT_COUNT_ZERO))
      else $error("running with zero period or count");

   a_running_alert: assert property (state_ff.running |->
      alert_out_n)
      else $error("alert active while counting");

   a_count_step: assert property (tick && (state_ff.count != ITT_COUNT_ONE) && !act_hit &&
      !wr_timeout |=> state_ff.running && (state_ff.count == $past(state_ff.count) - ITT_COUNT_ONE))
      else $error("minute tick did not decrement counter");

   a_masked_quiet: assert property (state_ff.running && !tick && !wr_timeout &&
      ((activity_irq & state_ff.mask) == ITT_MASK_RST) |=> $stable(state_ff.count))
      else $error("masked or quiet lines moved counter");

   a_reload_event: assert property (state_ff.running && act_hit && !wr_timeout |=>
      state_ff.int_stat[ITT_EV_RELOAD])
      else $error("reload event not recorded");

   a_reload_presc: assert property (state_ff.running && act_hit && !wr_timeout |=>
      (state_ff.presc == ITT_PRESC_ZERO) && state_ff.running)
      else $error("activity did not restart the minute");

   a_tick_presc: assert property (tick && !act_hit && !wr_timeout |=>
      (state_ff.presc == ITT_PRESC_ZERO))
      else $error("prescaler not cleared on tick");

   a_presc_step: assert property (state_ff.running && !tick && !act_hit && !wr_timeout |=>
      (state_ff.presc == $past(state_ff.presc) + ITT_PRESC_ONE))
      else $error("prescaler did not advance");

   a_presc_bound: assert property (state_ff.presc <= TICK_LAST)
      else $error("prescaler beyond minute length");

   a_write_period: assert property (wr_timeout |=>
      (state_ff.period == $past(wb_req.dat[7:0])))
      else $error("timeout write did not store period");

   a_period_read: assert property (bus_rd && idx_ok && (bus_idx == ITT_IDX_TIMEOUT) |=>
      wb_rsp.ack && (wb_rsp.dat == {24'h00_0000, $past(state_ff.period)}))
      else $error("period read back wrong");

   a_mask_write: assert property (bus_wr && idx_ok && (bus_idx == ITT_IDX_MASK) |=>
      (state_ff.mask == $past(wb_req.dat[ITT_SRC_N-1:0])))
      else $error("mask write not stored");

   a_mask_read: assert property (bus_rd && idx_ok && (bus_idx == ITT_IDX_MASK) |=>
      (wb_rsp.dat[ITT_SRC_N-1:0] == $past(state_ff.mask)))
      else $error("mask read back wrong");

   a_stat_clear: assert property (bus_rd && idx_ok && (bus_idx == ITT_IDX_INT_STAT) && !state_ff.running |=>
      (state_ff.int_stat == ITT_EV_RST))
      else $error("event status not cleared by read");

   a_write_no_data: assert property (bus_req && wb_req.we |=>
      (wb_rsp.dat == ITT_DAT_ZERO))
      else $error("write answered with data");

   a_ack_source: assert property (wb_rsp.ack |->
      $past(bus_req))
      else $error("ack without a taken request");

   a_route_active: assert property (!alert_out_n && state_ff.route[ITT_ROUTE_EN_BIT] |->
      (alert_irq == (16'h0001 << state_ff.route[ITT_ROUTE_SEL_W-1:0])))
      else $error("routed line not held while alert active");

   a_route_idle: assert property (alert_out_n || !state_ff.route[ITT_ROUTE_EN_BIT] |->
      (alert_irq == 16'h0000))
      else $error("alert lines active without routed alert");

endmodule

// [dv/itt_act_model.sv]
// Peripheral interrupt request lines that feed the timer's activity inputs.
`timescale 1ns/10ps
module itt_act_model
   import itt_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [ITT_SRC_N-1:0] fire,
   output logic [ITT_SRC_N-1:0] activity_irq
);
   // A line holds for two cycles, as a serviced peripheral drops its request soon after.
   logic [ITT_SRC_N-1:0] hold_ff;
   always_ff @(posedge clk) begin
      if (srst) begin
         hold_ff <= '0;
         activity_irq <= '0;
      end else begin
         hold_ff <= fire;
         activity_irq <= fire | hold_ff;
      end
   end
endmodule

// [dv/tb.sv]
// Self-checking bench of the inactivity timeout timer.
`timescale 1ns/10ps
module tb
   import itt_pkg::*;
;
   localparam int T = 8;
   logic clk;
   logic srst;
   itt_wb_req_t req;
   itt_wb_rsp_t rsp;
   logic [ITT_SRC_N-1:0] fire;
   logic [ITT_SRC_N-1:0] act;
   logic alert_out_n;
   logic [ITT_IRQ_LINES-1:0] alert_irq;
   logic irq;
   logic [7:0] q;
   logic [7:0] p;
   logic [3:0] m;
   logic [3:0] s;
   int miscompares;
   int cmp_count;
   itt_timer #(
      .TICK_CYCLES(33'h0_0000_0008)
   ) u_dut (
      .clk(clk),
      .srst(srst),
      .wb_req(req),
      .wb_rsp(rsp),
      .activity_irq(act),
      .alert_out_n(alert_out_n),
      .alert_irq(alert_irq),
      .irq(irq)
   );
   itt_act_model u_src (
      .clk(clk),
      .srst(srst),
      .fire(fire),
      .activity_irq(act)
   );
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // Checking and bus tasks
   // ---------------------------------------------------------------
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic logic [15:0] line_of(input logic [3:0] sel);
      return 16'h0001 << sel;
   endfunction
   // The request stands until ack is sampled, so a slow answer never tears a transfer.
   task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] d, output logic [7:0] rd);
      int n;
      @(posedge clk);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, ITT_ADR_ALIGN}, sel: 4'hF, dat: {24'h000000, d}};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         results();
      end
      rd = rsp.dat[7:0];
      req <= '0;
   endtask
   // Sampling 1 ns after the edge lets the design's registers settle first.
   task automatic run(input logic [7:0] per, input logic [3:0] f, input int off, input logic [7:0] ev);
      wb(1'b1, ITT_IDX_TIMEOUT, per, q);
      chk("alert_released", 16'(alert_out_n), 16'h0001);
      repeat (4) @(posedge clk);
      fire <= f;
      @(posedge clk);
      fire <= '0;
      repeat (int'(per) * T + off - 7) @(posedge clk);
      #1;
      chk("alert_before_expiry", 16'(alert_out_n), 16'h0001);
      repeat (3) @(posedge clk);
      #1;
      chk("alert_after_expiry", 16'(alert_out_n), 16'h0000);
      wb(1'b0, ITT_IDX_STATUS, 8'h00, q);
      chk("status_active", 16'(q), 16'h0000);
      chk("irq_level", 16'(irq), 16'h0001);
      chk("routed_line", alert_irq, line_of(s));
      wb(1'b0, ITT_IDX_INT_STAT, 8'h00, q);
      chk("event_status", 16'(q), 16'(ev));
      wb(1'b0, ITT_IDX_INT_STAT, 8'h00, q);
      chk("event_cleared", 16'(q), 16'h0000);
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      srst = 1'b1;
      req = '0;
      fire = '0;
      miscompares = 0;
      cmp_count = 0;
      void'($urandom(32'hC7BB));
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk("alert_reset", 16'(alert_out_n), 16'h0001);
      chk("lines_reset", alert_irq | 16'(irq), 16'h0000);
      for (int i = 0; i < 3; i++) begin
         wb(1'b0, 6'(i), 8'h00, q);
         chk("reset_value", 16'(q), (i == 2) ? 16'h0001 : 16'h0000);
      end
      wb(1'b1, 6'h03, 8'hFF, q);
      wb(1'b0, 6'h03, 8'h00, q);
      chk("unmapped_read", 16'(q), 16'h0000);
      p = 8'($urandom);
      wb(1'b1, ITT_IDX_MASK, p, q);
      wb(1'b0, ITT_IDX_MASK, 8'h00, q);
      chk("mask_readback", 16'(q), 16'(p & 8'h0F));
      s = 4'($urandom);
      wb(1'b1, ITT_IDX_ROUTE, {4'h8, s}, q);
      wb(1'b1, ITT_IDX_INT_MASK, 8'h03, q);
      wb(1'b0, ITT_IDX_ROUTE, 8'h00, q);
      chk("route_readback", 16'(q), 16'({4'h8, s}));
      wb(1'b0, ITT_IDX_INT_MASK, 8'h00, q);
      chk("event_mask_readback", 16'(q), 16'h0003);
      m = 4'h1 << ($urandom % 4);
      wb(1'b1, ITT_IDX_MASK, {4'h0, m}, q);
      run(8'(1 + $urandom % 4), 4'h0, 0, 8'h01);
      // A zero write must release the alert and keep it released.
      wb(1'b1, ITT_IDX_TIMEOUT, 8'h00, q);
      chk("zero_release", 16'(alert_out_n), 16'h0001);
      wb(1'b1, ITT_IDX_TIMEOUT, 8'h01, q);
      wb(1'b1, ITT_IDX_TIMEOUT, 8'h00, q);
      repeat (4 * T) @(posedge clk);
      #1;
      chk("stopped_alert", 16'(alert_out_n), 16'h0001);
      chk("stopped_line", alert_irq, 16'h0000);
      wb(1'b0, ITT_IDX_STATUS, 8'h00, q);
      chk("status_released", 16'(q), 16'h0001);
      // Masked lines must not stretch the countdown; an unmasked one restarts it.
      run(8'(1 + $urandom % 4), ~m, 0, 8'h01);
      run(8'(2 + $urandom % 3), m, 7, 8'h03);
      // A short period written mid-count replaces the long one at once.
      wb(1'b1, ITT_IDX_TIMEOUT, 8'hFF, q);
      wb(1'b0, ITT_IDX_TIMEOUT, 8'h00, q);
      chk("period_readback", 16'(q), 16'h00FF);
      repeat (2 * T) @(posedge clk);
      run(8'h01, 4'h0, 0, 8'h01);
      // A reset after expiry must release the raised alert, quiet the lines and clear the mask.
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk("alert_rereset", 16'(alert_out_n), 16'h0001);
      chk("lines_rereset", alert_irq | 16'(irq), 16'h0000);
      wb(1'b0, ITT_IDX_MASK, 8'h00, q);
      chk("mask_rereset", 16'(q), 16'h0000);
      results();
   end
endmodule
